/* rtl/sai_map.svh */
// Register offsets, field positions, reset values and timing counts
// for the serial audio ingest block.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef SAI_MAP_SVH
`define SAI_MAP_SVH

// Register byte offsets
`define SAI_OFS_CTRL     12'h000
`define SAI_OFS_DPATH    12'h004
`define SAI_OFS_AUDCFG   12'h008
`define SAI_OFS_STATUS   12'h00c
`define SAI_OFS_SAMPLE   12'h010

// Control register fields
`define SAI_CTRL_PKT_OFF     0
`define SAI_CTRL_LEGACY_RX   1
`define SAI_CTRL_SURR_RX_OK  2
`define SAI_CTRL_TDM         3
`define SAI_CTRL_WLEN_LO     4
`define SAI_CTRL_WLEN_HI     5
`define SAI_CTRL_RESET       6'h00

// Datapath control fields
`define SAI_DP_DUAL          0
`define SAI_DP_SURROUND      1
`define SAI_DP_FOUR_AB       2
`define SAI_DP_RESET         3'h0

// Audio configuration fields
`define SAI_AC_SPLIT         0

// Status fields
`define SAI_ST_PACKET        0
`define SAI_ST_SURROUND      1
`define SAI_ST_BCLK_LOST     2
`define SAI_ST_OVERRUN       3
`define SAI_ST_PEND_LO       4
`define SAI_ST_PEND_HI       7

// Word lengths selected by the two-bit length field
`define SAI_WLEN_16          7'h10
`define SAI_WLEN_24          7'h18
`define SAI_WLEN_32          7'h20
`define SAI_WLEN_64          7'h40
`define SAI_CAP_MAX          7'h20

// Data line masks per transport choice
`define SAI_MASK_A           4'h1
`define SAI_MASK_AB          4'h3
`define SAI_MASK_ALL         4'hf

// Bit clock limits and the derived watchdog count
`define SAI_PCLK_HZ          10000000
`define SAI_BCLK_MIN_HZ      1000000
`define SAI_BCLK_MAX_HZ      13000000
`define SAI_BCLK_TMO_CYC     (`SAI_PCLK_HZ / `SAI_BCLK_MIN_HZ)

`endif

/* rtl/sai_pkg.sv */
// Types shared by the serial audio ingest block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package sai_pkg;

    typedef enum logic {SAI_TR_PACKET, SAI_TR_FRAME} sai_transport_t;

    // One audio word handed to a downstream port
    typedef struct packed {
        logic           valid;
        sai_transport_t transport;
        logic [1:0]     pos;
        logic [2:0]     chan;
        logic [31:0]    data;
    } sai_word_t;

    // Raw audio pins, sampled together
    typedef struct packed {
        logic       bclk;
        logic       ws;
        logic [3:0] line;
    } sai_pins_t;

endpackage

/* rtl/sai_ingest.sv */
// Serial audio ingest stage: APB registers, pin sampling, word capture,
// transport choice and per-port channel mapping.
// Assumes audio pins asynchronous to pclk and link logic on pclk.
// Function
// RQ1 - Bit clock 1 MHz up to CLK/2 or 13 MHz
// RQ2 - Four data lines, two channels each
// RQ3 - Stereo words of 16, 24, 32 bits
// RQ4 - Reset default: packets sent only in blanking
// RQ5 - Packets off: frame transport, A or A+B
// RQ6 - Surround only with packets and capable receiver; upstream surround here sets surround without surr_rx_ok
// RQ7 - Repeater forwards by packet transport by default
// RQ8 - Upstream surround forces surround packet transport
// RQ9 - Software sets A+B four-channel in every node
// RQ10 - Split clear: same audio on both ports
// RQ11 - Split set: port 1 carries C,D,A,B
// RQ12 - Stereo split: port 1 carries line C
// RQ13 - Split bit resets from strap, writable later
// RQ14 - TDM: configurable word length and channels
// RQ15 - Rising edge, MSB first, one-bit delay
`timescale 1ns/100ps
`include "sai_map.svh"

module sai_ingest (
    // APB slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Audio source pins
    input  wire logic             audio_bit_clock,
    input  wire logic             audio_word_select,
    input  wire logic             audio_line_a,
    input  wire logic             audio_line_b,
    input  wire logic             audio_line_c,
    input  wire logic             audio_line_d,
    input  wire logic             splitter_strap,
    // Link side
    input  wire logic             video_blank,
    input  wire logic             upstream_surround,
    output sai_pkg::sai_word_t    port0_word,
    output sai_pkg::sai_word_t    port1_word
);

    // Pin sampling
    sai_pkg::sai_pins_t pins_in;
    sai_pkg::sai_pins_t pins_s1_q;
    sai_pkg::sai_pins_t pins_s2_q;
    logic               bclk_prev_q;
    logic               strap_s1_q;
    logic               strap_s2_q;

    // Registers
    logic [5:0]         ctrl_q;
    logic [2:0]         dpath_q;
    logic               split_q;
    logic               overrun_q;
    logic [1:0]         init_q;
    logic [31:0]        prdata_q;
    logic [31:0]        sample_q;

    // Capture state
    logic [6:0]         bit_cnt_q;
    logic [2:0]         slot_q;
    logic               ws_prev_q;
    logic               sync_q;
    logic [7:0]         idle_q;
    logic [31:0]        sreg_q [4];
    logic [31:0]        hold_q [4];
    logic [2:0]         hchan_q [4];
    logic [3:0]         pend_q;

    sai_pkg::sai_word_t port0_q;
    sai_pkg::sai_word_t port1_q;

    assign pins_in = '{bclk: audio_bit_clock, ws: audio_word_select,
                       line: {audio_line_d, audio_line_c,
                              audio_line_b, audio_line_a}};

    // Two flops per pin; only the second stage feeds any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_s1_q   <= '0;
            pins_s2_q   <= '0;
            bclk_prev_q <= 1'b0;
            strap_s1_q  <= 1'b0;
            strap_s2_q  <= 1'b0;
        end else begin
            pins_s1_q   <= pins_in;
            pins_s2_q   <= pins_s1_q;
            bclk_prev_q <= pins_s2_q.bclk;
            strap_s1_q  <= splitter_strap;
            strap_s2_q  <= strap_s1_q;
        end
    end

    // Control decode
    wire       pkt_off    = ctrl_q[`SAI_CTRL_PKT_OFF];
    wire       legacy_rx  = ctrl_q[`SAI_CTRL_LEGACY_RX];
    wire       surr_rx_ok = ctrl_q[`SAI_CTRL_SURR_RX_OK];
    wire       tdm        = ctrl_q[`SAI_CTRL_TDM];
    wire [1:0] wlen_sel   = ctrl_q[`SAI_CTRL_WLEN_HI:`SAI_CTRL_WLEN_LO];
    wire       dual       = dpath_q[`SAI_DP_DUAL];
    wire       surr_en    = dpath_q[`SAI_DP_SURROUND];
    wire       four_ab    = dpath_q[`SAI_DP_FOUR_AB];

    // Upstream surround overrides a local frame-transport setting
    wire packet_mode = ~pkt_off | upstream_surround;           // [RQ4] [RQ7] [RQ8]
    wire surround    = packet_mode &
                       ((surr_en & surr_rx_ok) | upstream_surround); // [RQ6] [RQ8]

    // Lines carried; A+B four-channel only when software asks for it
    wire [3:0] line_mask = ~packet_mode ?
                           (legacy_rx ? `SAI_MASK_AB : `SAI_MASK_A) : // [RQ5]
                           surround ? `SAI_MASK_ALL :                 // [RQ6]
                           four_ab ? `SAI_MASK_AB : `SAI_MASK_A;      // [RQ9]

    // Slot length and captured length; only 32 bits of a long slot kept
    wire [6:0] slot_len = (wlen_sel == 2'h0) ? `SAI_WLEN_16 :
                          (wlen_sel == 2'h1) ? `SAI_WLEN_24 :
                          (wlen_sel == 2'h2) ? `SAI_WLEN_32 :
                                               `SAI_WLEN_64;  // [RQ3] [RQ14]
    wire [6:0] cap_len  = (slot_len > `SAI_CAP_MAX) ?
                          `SAI_CAP_MAX : slot_len;

    // Bit clock edges and framing
    wire bclk_rise  = pins_s2_q.bclk & ~bclk_prev_q;               // [RQ15]
    wire cur_ws     = pins_s2_q.ws;
    wire ws_change  = cur_ws ^ ws_prev_q;
    wire [6:0] cnt_inc   = 7'(bit_cnt_q + 7'h01);
    wire slot_end   = (cnt_inc == slot_len);
    // I2S: every select change; TDM: rising select marks slot 0
    wire frame_edge = tdm ? (cur_ws & ~ws_prev_q) : ws_change;     // [RQ14]
    // The bit on the select edge is the last bit of the old word
    wire word_done  = sync_q & (tdm ? slot_end : ws_change);       // [RQ15]
    wire take_bit   = (bit_cnt_q < cap_len);
    wire [2:0] word_chan = tdm ? slot_q : {2'b00, ws_prev_q};      // [RQ2]

    // Where each line lands on port 1
    wire       split_on = dual & split_q;
    wire [3:0] p1_mask  = split_on ?
                          {line_mask[1:0], line_mask[3:2]} : line_mask;
    wire [3:0] need     = line_mask | (dual ? p1_mask : 4'h0);

    // Shift registers per data line, MSB first
    logic [31:0] word_val [4];
    logic [3:0]  set_vec;
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            word_val[l] = take_bit ? {sreg_q[l][30:0], pins_s2_q.line[l]}
                                   : sreg_q[l];
            set_vec[l]  = bclk_rise & word_done & need[l];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < 4; l++) begin
                sreg_q[l]  <= '0;
                hold_q[l]  <= '0;
                hchan_q[l] <= '0;
            end
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (bclk_rise) begin
                    sreg_q[l] <= (word_done | frame_edge) ? '0 : word_val[l];
                end
                if (set_vec[l]) begin
                    hold_q[l]  <= word_val[l];                     // [RQ2]
                    hchan_q[l] <= word_chan;
                end
            end
        end
    end

    // Bit and slot counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= '0;
            slot_q    <= '0;
            ws_prev_q <= 1'b0;
            sync_q    <= 1'b0;
        end else if (bclk_rise) begin
            ws_prev_q <= cur_ws;
            if (frame_edge) begin
                sync_q <= 1'b1;
            end
            if (word_done | frame_edge) begin
                bit_cnt_q <= '0;
            end else if (bit_cnt_q != 7'h7f) begin
                bit_cnt_q <= cnt_inc;
            end
            if (frame_edge) begin
                slot_q <= '0;
            end else if (word_done) begin
                slot_q <= 3'(slot_q + 3'h1);
            end
        end
    end

    // Bit clock watchdog: slower than the least rate reads as lost
    wire [7:0] tmo_cyc  = 8'(`SAI_BCLK_TMO_CYC);
    wire       bclk_lost = (idle_q >= tmo_cyc);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= '0;
        end else if (bclk_rise) begin
            idle_q <= '0;                                         // [RQ1]
        end else if (!bclk_lost) begin
            idle_q <= 8'(idle_q + 8'h01);
        end
    end

    // Emission: packets wait for blanking, frame words go at once
    wire       window   = ~packet_mode | video_blank;              // [RQ4] [RQ5]
    wire [3:0] eligible = pend_q & {4{window}};
    wire       any_out  = |eligible;
    wire [1:0] pick     = eligible[0] ? 2'h0 :
                          eligible[1] ? 2'h1 :
                          eligible[2] ? 2'h2 : 2'h3;
    wire [3:0] taken    = any_out ? 4'(4'h1 << pick) : 4'h0;
    // Port 1 position of a line; the swap trades upper and lower pairs
    wire [1:0] p1_pos   = split_on ? (pick ^ 2'h2) : pick;         // [RQ11]
    wire sai_pkg::sai_transport_t tr_now =
        packet_mode ? sai_pkg::SAI_TR_PACKET : sai_pkg::SAI_TR_FRAME;

    // A new word while one is still held overwrites it; flagged
    wire ovr_set = |(set_vec & pend_q & ~taken);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~taken) | set_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_q <= '0;
            port1_q <= '0;
        end else begin
            port0_q <= '{valid: any_out & line_mask[pick],
                         transport: tr_now, pos: pick,
                         chan: hchan_q[pick], data: hold_q[pick]};
            // Split clear: identical copy; split set: swapped pairs
            // The port 1 mask is indexed by source line, not position
            port1_q <= '{valid: any_out & dual & p1_mask[pick], // [RQ10] [RQ12]
                         transport: tr_now, pos: p1_pos,
                         chan: hchan_q[pick], data: hold_q[pick]};
        end
    end

    assign port0_word = port0_q;
    assign port1_word = port1_q;

    // APB decode
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire hit_ctrl  = (paddr == `SAI_OFS_CTRL);
    wire hit_dpath = (paddr == `SAI_OFS_DPATH);
    wire hit_acfg  = (paddr == `SAI_OFS_AUDCFG);
    wire hit_stat  = (paddr == `SAI_OFS_STATUS);
    wire hit_samp  = (paddr == `SAI_OFS_SAMPLE);
    wire mapped    = hit_ctrl | hit_dpath | hit_acfg | hit_stat | hit_samp;
    wire wr        = access & pwrite & mapped;
    wire ovr_clr   = wr & hit_stat & pwdata[`SAI_ST_OVERRUN];

    wire [31:0] status_val = {24'h0, pend_q, overrun_q, bclk_lost,
                              surround, packet_mode};
    wire [31:0] rd_mux =
        hit_ctrl  ? {26'h0, ctrl_q}  :
        hit_dpath ? {29'h0, dpath_q} :
        hit_acfg  ? {31'h0, split_q} :
        hit_stat  ? status_val       :
        hit_samp  ? sample_q         : 32'h0;

    // Zero wait states; read data fetched in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata  = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

    // Control registers; reset selects packet transport
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `SAI_CTRL_RESET;                            // [RQ4] [RQ7]
            dpath_q <= `SAI_DP_RESET;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[5:0];
            end
            if (hit_dpath) begin
                dpath_q <= pwdata[2:0];                            // [RQ9]
            end
        end
    end

    // Strap is caught once the synchroniser has settled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q  <= '0;
            split_q <= 1'b0;
        end else begin
            if (init_q != 2'h3) begin
                init_q <= 2'(init_q + 2'h1);
            end
            if (init_q == 2'h2) begin
                split_q <= strap_s2_q;                             // [RQ13]
            end else if (wr & hit_acfg) begin
                split_q <= pwdata[`SAI_AC_SPLIT];                  // [RQ13]
            end
        end
    end

    // Sticky overrun: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_q <= 1'b0;
        end else begin
            overrun_q <= ovr_set | (overrun_q & ~ovr_clr);
        end
    end

    // Latest line A word, for software inspection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q <= '0;
        end else if (set_vec[0]) begin
            sample_q <= word_val[0];
        end
    end

endmodule

/* sim/sai_ingest_assertions.sv */
// Port checks for the serial audio ingest stage.
// Assumes one pclk domain and the shared register map header.
`timescale 1ns/100ps
`include "sai_map.svh"

module sai_ingest_assertions (
    // APB
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic        [11:0] paddr,
    input wire logic        [31:0] prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Link side
    input wire logic               video_blank,
    input wire logic               upstream_surround,
    input wire sai_pkg::sai_word_t port0_word,
    input wire sai_pkg::sai_word_t port1_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic mapped;
    assign mapped = paddr inside {`SAI_OFS_CTRL, `SAI_OFS_DPATH,
        `SAI_OFS_AUDCFG, `SAI_OFS_STATUS, `SAI_OFS_SAMPLE};

    sequence s_access;
        psel && penable;
    endsequence
    // Forcing is level based, so give it a few cycles to settle
    sequence s_up_held;
        upstream_surround [*4];
    endsequence
    sequence s_two_words;
        port0_word.valid ##1 port0_word.valid;
    endsequence

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_map: assert property (
        pslverr == (psel && penable && !mapped))
        else $error("pslverr wrong for address");
    a_err_zero: assert property (
        s_access ##0 (pslverr && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_pkt_blank0: assert property (
        port0_word.valid && port0_word.transport == sai_pkg::SAI_TR_PACKET
        |-> $past(video_blank))
        else $error("port0 packet outside blanking");
    a_pkt_blank1: assert property (
        port1_word.valid && port1_word.transport == sai_pkg::SAI_TR_PACKET
        |-> $past(video_blank))
        else $error("port1 packet outside blanking");
    a_frame_pos0: assert property (
        port0_word.valid && port0_word.transport == sai_pkg::SAI_TR_FRAME
        |-> port0_word.pos <= 2'd1)
        else $error("port0 frame transport beyond line B");
    a_frame_pos1: assert property (
        port1_word.valid && port1_word.transport == sai_pkg::SAI_TR_FRAME
        |-> port1_word.pos <= 2'd1)
        else $error("port1 frame transport beyond line B");
    a_up_packet: assert property (
        s_up_held ##0 port0_word.valid
        |-> port0_word.transport == sai_pkg::SAI_TR_PACKET)
        else $error("upstream surround not in packets");
    a_line_order: assert property (
        s_two_words |-> port0_word.pos > $past(port0_word.pos))
        else $error("lines not emitted lowest first");
endmodule

bind sai_ingest sai_ingest_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .video_blank(video_blank),
    .upstream_surround(upstream_surround), .port0_word(port0_word),
    .port1_word(port1_word));

/* sim/sai_audio_src.sv */
// Audio source model: plays queued bits of word select and data lines.
// Assumes the bench fills a whole burst in one time step.
`timescale 1ns/100ps

module sai_audio_src (
    // Pins toward the block
    output logic       bclk,
    output logic       ws,
    output logic [3:0] line
);
    // 800 ns period sits inside the accepted bit clock range
    localparam time HALF = 400;
    bit         ws_q[$];
    logic [3:0] ln_q[$];

    initial begin
        bclk = 1'b0;
        ws   = 1'b0;
        line = 4'h0;
        forever begin
            wait (ws_q.size() != 0);
            // Change on the falling edge, so the rising edge samples
            ws   = ws_q.pop_front();
            line = ln_q.pop_front();
            #HALF bclk = 1'b1;
            #HALF bclk = 1'b0;
            // Clock stands still between bursts; lines stop holding data
            if (ws_q.size() == 0) line = ~line;
        end
    end
endmodule

/* sim/tb.sv */
// Bench: APB master, audio source and a queue model of the port words.
// Assumes the shared register map header and the source model.
`timescale 1ns/100ps
`include "sai_map.svh"

module tb;
    logic               pclk, presetn, psel, penable, pwrite, pready;
    logic               pslverr, splitter_strap, video_blank, up;
    logic               bclk, ws, live;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata, ctrl, dp, ac, q, last_a;
    logic        [31:0] rs = 32'h2c;
    logic         [3:0] line;
    sai_pkg::sai_word_t port0_word, port1_word;
    sai_pkg::sai_word_t expq[2][$];
    int                 num_errors, n_compared;
    int                 lens[3] = '{16, 24, 32};
    // Scenario table: control, datapath, split, upstream surround
    logic         [5:0] tc[8] = '{6'h00, 6'h00, 6'h04, 6'h14,
                                  6'h25, 6'h03, 6'h01, 6'h08};
    logic         [2:0] td[8] = '{3'h1, 3'h1, 3'h3, 3'h5,
                                  3'h2, 3'h1, 3'h0, 3'h0};
    logic               ta[8] = '{0, 1, 1, 0, 0, 1, 0, 0};
    logic               tu[8] = '{0, 0, 0, 0, 0, 0, 1, 0};

    sai_audio_src u_src (.bclk(bclk), .ws(ws), .line(line));
    sai_ingest u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .audio_bit_clock(bclk),
        .audio_word_select(ws), .audio_line_a(line[0]),
        .audio_line_b(line[1]), .audio_line_c(line[2]),
        .audio_line_d(line[3]), .splitter_strap(splitter_strap),
        .video_blank(video_blank), .upstream_surround(up),
        .port0_word(port0_word), .port1_word(port1_word));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    always @(posedge pclk) video_blank <= rnd() > 32'h7fffffff;

    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask

    task automatic bail(string nm);
        chk(nm, 32'h1, 32'h0);
        finish_test();
    endtask

    task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bail("pready");
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(string nm, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic do_reset(logic strap);
        splitter_strap <= strap;
        presetn        <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn        <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic pk();
        return up || !ctrl[`SAI_CTRL_PKT_OFF];
    endfunction

    function automatic logic [3:0] lmask();
        if (!pk()) return ctrl[`SAI_CTRL_LEGACY_RX] ? `SAI_MASK_AB
                                                    : `SAI_MASK_A;
        if (up || (dp[`SAI_DP_SURROUND] && ctrl[`SAI_CTRL_SURR_RX_OK]))
            return `SAI_MASK_ALL;
        return dp[`SAI_DP_FOUR_AB] ? `SAI_MASK_AB : `SAI_MASK_A;
    endfunction

    task automatic want(int l, int c, logic [31:0] d);
        sai_pkg::sai_word_t w;
        logic         [3:0] m;
        int                 p;
        m = lmask();
        w.valid     = 1'b1;
        w.transport = pk() ? sai_pkg::SAI_TR_PACKET : sai_pkg::SAI_TR_FRAME;
        w.pos       = 2'(l);
        w.chan      = 3'(c);
        w.data      = d;
        if (m[l]) expq[0].push_back(w);
        if (l == 0) last_a = d;
        p = (dp[`SAI_DP_DUAL] && ac[`SAI_AC_SPLIT]) ? l ^ 2 : l;
        w.pos = 2'(p);
        if (dp[`SAI_DP_DUAL] && m[p]) expq[1].push_back(w);
    endtask

    task automatic put(bit w, logic [3:0] l);
        u_src.ws_q.push_back(w);
        u_src.ln_q.push_back(l);
    endtask

    // Stereo frame; select flips with the last bit of each word
    task automatic i2s(int len);
        logic [31:0] wd[2][4];
        logic  [3:0] b;
        for (int c = 0; c < 2; c++)
            for (int l = 0; l < 4; l++) begin
                wd[c][l] = rnd() >> (32 - len);
                if (live) want(l, c, wd[c][l]);
            end
        for (int k = 0; k < 2 * len; k++) begin
            for (int l = 0; l < 4; l++) b[l] = wd[k / len][l][len - 1 - k % len];
            put(k >= len - 1 && k < 2 * len - 1, b);
        end
    endtask

    task automatic tdm(int slots, int len);
        logic [31:0] wd[4];
        logic  [3:0] b;
        put(1'b1, 4'(rnd()));
        for (int s = 0; s < slots; s++) begin
            for (int l = 0; l < 4; l++) begin
                wd[l] = rnd() >> (32 - len);
                want(l, s, wd[l]);
            end
            for (int k = len - 1; k >= 0; k--) begin
                for (int l = 0; l < 4; l++) b[l] = wd[l][k];
                put(1'b0, b);
            end
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while ((u_src.ws_q.size() || expq[0].size() || expq[1].size())
               && n < 6000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 6000) bail("drain");
        repeat (20) @(posedge pclk);
    endtask

    always @(posedge pclk) begin : mon
        sai_pkg::sai_word_t w, e;
        int                 hit;
        for (int p = 0; p < 2; p++) begin
            w   = p ? port1_word : port0_word;
            e   = '0;
            hit = -1;
            if (expq[p].size()) e = expq[p][0];
            for (int i = 0; i < expq[p].size(); i++)
                if (expq[p][i] === w) hit = i;
            if (live && w.valid === 1'b1) begin
                n_compared++;
                if (hit < 0) begin
                    num_errors++;
                    $display("CHECK FAILED port word exp %h got %h", e, w);
                end else begin
                    expq[p].delete(hit);
                end
            end
        end
    end

    initial begin
        {psel, penable, pwrite, up, live, video_blank} = '0;
        {presetn, splitter_strap, ctrl, dp, ac} = '0;
        paddr      = '0;
        pwdata     = '0;
        num_errors = 0;
        n_compared = 0;
        do_reset(1'b0);
        rd("split_rst", `SAI_OFS_AUDCFG, 32'h0);
        do_reset(1'b1);
        rd("ctrl_rst", `SAI_OFS_CTRL, 32'h0);
        rd("dpath_rst", `SAI_OFS_DPATH, 32'h0);
        rd("split_strap", `SAI_OFS_AUDCFG, 32'h1);
        apb(1'b1, `SAI_OFS_CTRL, '1);
        rd("ctrl_rw", `SAI_OFS_CTRL, 32'h3f);
        apb(1'b1, `SAI_OFS_DPATH, '1);
        rd("dpath_rw", `SAI_OFS_DPATH, 32'h7);
        apb(1'b1, `SAI_OFS_AUDCFG, 32'h0);
        rd("split_wr", `SAI_OFS_AUDCFG, 32'h0);
        rd("unmapped", 12'h014, 32'h0);
        apb(1'b1, `SAI_OFS_CTRL, 32'h0);
        apb(1'b1, `SAI_OFS_DPATH, 32'h0);
        // First word after reset is dropped, so prime the framing
        i2s(16);
        drain();
        live = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ctrl = 32'(tc[i]);
            dp   = 32'(td[i]);
            ac   = 32'(ta[i]);
            up  <= tu[i];
            apb(1'b1, `SAI_OFS_CTRL, ctrl);
            apb(1'b1, `SAI_OFS_DPATH, dp);
            apb(1'b1, `SAI_OFS_AUDCFG, ac);
            rd("status", `SAI_OFS_STATUS, {28'h0, 1'b0, 1'b1,
               lmask() == `SAI_MASK_ALL, pk()});
            if (ctrl[`SAI_CTRL_TDM]) tdm(8, 16);
            else repeat (2) i2s(lens[ctrl[5:4]]);
            drain();
            rd("sample", `SAI_OFS_SAMPLE, last_a);
        end
        finish_test();
    end
endmodule
